// >>> rtl/smb_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "smb_map.svh"
module smb_device (
  input  wire logic CLK_SYS,                 // System clock
  input  wire logic RESET_N,                 // Async reset, low
  smb_bus_if.dev    BUS,                     // Stacked memory pins
  output logic [`SMB_FLASH_DIES-1:0] ACTIVE_FLASH, // Flash die active
  output logic      ACTIVE_SRAM,             // SRAM active
  output logic [`SMB_PSRAM_DIES-1:0] ACTIVE_PSRAM, // PSRAM die active
  output logic      WAIT_POL                 // Configured wait polarity
);
  localparam int NF = `SMB_FLASH_DIES;
  localparam int NP = `SMB_PSRAM_DIES;
  localparam int AW = `SMB_ADDR_W;
  localparam int DW = `SMB_DATA_W;
  localparam int IW = `SMB_MEM_IDX_W;

  // Synchronised pins
  logic [AW-1:0] addr_s1_r, addr_s2_r;
  logic [DW-1:0] din_s1_r, din_s2_r;
  logic [NF-1:0] fsel_s1_r, fsel_s2_r;
  logic [NP-1:0] psel_s1_r, psel_s2_r;
  logic [1:0]    foe_s1_r, foe_s2_r;
  logic [5:0]    ctl_s1_r, ctl_s2_r;
  logic [5:0]    ctl_in;
  assign ctl_in = {BUS.ram_we_n, BUS.flash_rst_n, BUS.flash_we_n,
                   BUS.ram_oe_n, BUS.sram_select_high_true,
                   BUS.sram_select_low_true};

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      addr_s1_r <= '0;
      addr_s2_r <= '0;
      din_s1_r  <= '0;
      din_s2_r  <= '0;
      fsel_s1_r <= '1;
      fsel_s2_r <= '1;
      psel_s1_r <= '1;
      psel_s2_r <= '1;
      foe_s1_r  <= 2'h3;
      foe_s2_r  <= 2'h3;
      ctl_s1_r  <= 6'h2D;
      ctl_s2_r  <= 6'h2D;
    end else begin
      addr_s1_r <= BUS.addr;
      addr_s2_r <= addr_s1_r;
      din_s1_r  <= BUS.dq_host_o;
      din_s2_r  <= din_s1_r;
      fsel_s1_r <= BUS.flash_sel_n;
      fsel_s2_r <= fsel_s1_r;
      psel_s1_r <= BUS.psram_sel_n;
      psel_s2_r <= psel_s1_r;
      foe_s1_r  <= BUS.flash_oe_n;
      foe_s2_r  <= foe_s1_r;
      ctl_s1_r  <= ctl_in;
      ctl_s2_r  <= ctl_s1_r;
    end
  end

  logic rwe_n_s, rst_n_s, we_n_s, roe_n_s, scs2_s, scs1_n_s;
  assign {rwe_n_s, rst_n_s, we_n_s, roe_n_s, scs2_s, scs1_n_s} = ctl_s2_r;

  function automatic logic [IW-1:0] word_idx(input logic [AW-1:0] a);
    return a[IW-1:0];
  endfunction

  // RAM die index from the PSRAM selects; SRAM is entry zero
  function automatic logic [1:0] ram_die(input logic [NP-1:0] p);
    return p[1] ? 2'h2 : (p[0] ? 2'h1 : 2'h0);
  endfunction

  // State
  smb_pkg::smb_flash_mode_type mode_r [NF], mode_nxt [NF];
  logic [DW-1:0] rcr_r [NF], rcr_nxt [NF];
  logic [DW-1:0] fmem_r [NF][`SMB_MEM_WORDS];
  logic [DW-1:0] rmem_r [3][`SMB_MEM_WORDS];
  logic          we_n_d_r, rwe_n_d_r, rwe_rise;
  logic [DW-1:0] dq_o_r, dq_o_nxt;
  logic          dq_oe_r, dq_oe_nxt, wait_r, wait_nxt, wait_oe_r, wait_oe_nxt;
  logic [NF-1:0] fact_nxt;
  logic [NP-1:0] pact_nxt;
  logic          sact_nxt;
  logic          we_rise;
  logic [NF-1:0] foe_die;

  assign we_rise = we_n_s && !we_n_d_r;

  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : g_flash
      // Enable two covers dies two and three
      assign foe_die[g] = (g == 0) ? !foe_s2_r[0] : !foe_s2_r[1];
      always_comb begin
        mode_nxt[g] = mode_r[g];
        rcr_nxt[g]  = rcr_r[g];
        if (!rst_n_s) begin
          mode_nxt[g] = smb_pkg::SMB_FL_READ_ARRAY;
        end else if (we_rise && !fsel_s2_r[g]) begin
          if (mode_r[g] == smb_pkg::SMB_FL_CFG_SETUP) begin
            case (din_s2_r)
              `SMB_CMD_SET_CFG: begin
                rcr_nxt[g]  = addr_s2_r[DW-1:0];
                mode_nxt[g] = smb_pkg::SMB_FL_READ_SYNC;
              end
              default: mode_nxt[g] = smb_pkg::SMB_FL_READ_ARRAY;
            endcase
          end else if (din_s2_r == `SMB_CMD_READ_CFG) begin
            mode_nxt[g] = smb_pkg::SMB_FL_CFG_SETUP;
          end else begin
            mode_nxt[g] = smb_pkg::SMB_FL_READ_ARRAY;
          end
        end
      end
      always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
          mode_r[g] <= smb_pkg::SMB_FL_READ_ARRAY;
          rcr_r[g]  <= `SMB_RCR_RESET;
        end else begin
          mode_r[g] <= mode_nxt[g];
          rcr_r[g]  <= rcr_nxt[g];
        end
      end
      always_ff @(posedge CLK_SYS) begin
        if (rst_n_s && we_rise && !fsel_s2_r[g] &&
            din_s2_r != `SMB_CMD_READ_CFG &&
            mode_r[g] != smb_pkg::SMB_FL_CFG_SETUP)
          fmem_r[g][word_idx(addr_s2_r)] <= din_s2_r;
      end
    end
  endgenerate

  // RAM stores the host word on its own strobe rise
  assign rwe_rise = rwe_n_s && !rwe_n_d_r;
  always_ff @(posedge CLK_SYS) begin
    if (rwe_rise && (sact_nxt || pact_nxt != '0))
      rmem_r[ram_die(pact_nxt)][word_idx(addr_s2_r)] <= din_s2_r;
  end

  always_comb begin
    // Select n maps to die n
    fact_nxt = ~fsel_s2_r & {NF{rst_n_s}};
    sact_nxt = !scs1_n_s && scs2_s;
    pact_nxt = ~psel_s2_r;
    dq_o_nxt    = '0;
    dq_oe_nxt   = 1'b0;
    wait_nxt    = 1'b0;
    wait_oe_nxt = 1'b0;
    for (int i = 0; i < NF; i++) begin
      if (fact_nxt[i]) begin
        wait_oe_nxt = 1'b1;
        wait_nxt    = (mode_r[i] == smb_pkg::SMB_FL_READ_SYNC) ?
                      !rcr_r[i][`SMB_RCR_WAIT_POL] :
                      rcr_r[i][`SMB_RCR_WAIT_POL];
        if (foe_die[i]) begin
          dq_oe_nxt = 1'b1;
          dq_o_nxt  = fmem_r[i][word_idx(addr_s2_r)];
        end
      end
    end
    if ((sact_nxt || pact_nxt != '0) && !roe_n_s) begin
      dq_oe_nxt = 1'b1;
      dq_o_nxt  = rmem_r[ram_die(pact_nxt)][word_idx(addr_s2_r)];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      we_n_d_r     <= 1'b1;
      rwe_n_d_r    <= 1'b1;
      dq_o_r       <= '0;
      dq_oe_r      <= 1'b0;
      wait_r       <= 1'b0;
      wait_oe_r    <= 1'b0;
      ACTIVE_FLASH <= '0;
      ACTIVE_SRAM  <= 1'b0;
      ACTIVE_PSRAM <= '0;
      WAIT_POL     <= 1'b1;
    end else begin
      we_n_d_r     <= we_n_s;
      rwe_n_d_r    <= rwe_n_s;
      dq_o_r       <= dq_o_nxt;
      dq_oe_r      <= dq_oe_nxt;
      wait_r       <= wait_nxt;
      wait_oe_r    <= wait_oe_nxt;
      ACTIVE_FLASH <= fact_nxt;
      ACTIVE_SRAM  <= sact_nxt;
      ACTIVE_PSRAM <= pact_nxt;
      WAIT_POL     <= rcr_r[0][`SMB_RCR_WAIT_POL];
    end
  end

  assign BUS.dq_dev_o  = dq_o_r;
  assign BUS.dq_dev_oe = dq_oe_r;
  assign BUS.wait_o    = wait_r;
  assign BUS.wait_oe   = wait_oe_r;
endmodule
`default_nettype wire

// >>> include/smb_map.svh
`ifndef SMB_MAP_SVH
`define SMB_MAP_SVH
// Bus geometry
`define SMB_ADDR_W      26
`define SMB_DATA_W      16
`define SMB_FLASH_DIES  3
`define SMB_PSRAM_DIES  2
// Top used address line per density
`define SMB_TOP_LINE_128 22
`define SMB_TOP_LINE_64  21
`define SMB_TOP_LINE_32  20
// Wait polarity bit in the read configuration register
`define SMB_RCR_WAIT_POL 10
`define SMB_RCR_RESET    16'h0400
// Flash commands and memory depth and index width
`define SMB_CMD_READ_ARRAY 16'h00FF
`define SMB_CMD_READ_CFG   16'h0060
`define SMB_CMD_SET_CFG    16'h0003
`define SMB_MEM_WORDS      16
`define SMB_MEM_IDX_W      4
`endif

// >>> include/smb_pkg.sv
package smb_pkg;
  typedef enum logic [1:0] {
    SMB_FL_READ_ARRAY = 2'b00,
    SMB_FL_CFG_SETUP  = 2'b01,
    SMB_FL_READ_SYNC  = 2'b10
  } smb_flash_mode_type;
  typedef enum logic [1:0] {
    SMB_H_IDLE  = 2'b00,
    SMB_H_READ  = 2'b01,
    SMB_H_WRITE = 2'b10,
    SMB_H_DONE  = 2'b11
  } smb_host_state_type;
  typedef enum logic [2:0] {
    SMB_T_FLASH1 = 3'b000,
    SMB_T_FLASH2 = 3'b001,
    SMB_T_FLASH3 = 3'b010,
    SMB_T_SRAM   = 3'b011,
    SMB_T_PSRAM1 = 3'b100,
    SMB_T_PSRAM2 = 3'b101
  } smb_target_type;
endpackage

// >>> include/smb_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "smb_map.svh"
interface smb_bus_if;
  logic [`SMB_ADDR_W-1:0]     addr;
  logic [`SMB_FLASH_DIES-1:0] flash_sel_n;
  logic                       sram_select_low_true;
  logic                       sram_select_high_true;
  logic [`SMB_PSRAM_DIES-1:0] psram_sel_n;
  logic [1:0]                 flash_oe_n;
  logic                       ram_oe_n;
  logic                       flash_we_n;
  logic                       ram_we_n;
  logic                       flash_rst_n;
  logic [`SMB_DATA_W-1:0]     dq_host_o;
  logic                       dq_host_oe;
  logic [`SMB_DATA_W-1:0]     dq_dev_o;
  logic                       dq_dev_oe;
  logic                       wait_o;
  logic                       wait_oe;
  modport host (output addr, flash_sel_n, sram_select_low_true,
                sram_select_high_true, psram_sel_n, flash_oe_n, ram_oe_n,
                flash_we_n, ram_we_n, flash_rst_n, dq_host_o, dq_host_oe,
                input dq_dev_o, dq_dev_oe, wait_o, wait_oe);
  modport dev (input addr, flash_sel_n, sram_select_low_true,
               sram_select_high_true, psram_sel_n, flash_oe_n, ram_oe_n,
               flash_we_n, ram_we_n, flash_rst_n, dq_host_o, dq_host_oe,
               output dq_dev_o, dq_dev_oe, wait_o, wait_oe);
endinterface
`default_nettype wire

// >>> rtl/smb_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "smb_map.svh"
module smb_host (
  input  wire logic CLK_SYS,                   // System clock
  input  wire logic RESET_N,                   // Async reset, low
  input  wire logic REQ,                       // Start access, pulse
  input  wire logic REQ_WRITE,                 // One for write
  input  wire smb_pkg::smb_target_type REQ_TARGET, // Die to access
  input  wire logic [`SMB_ADDR_W-1:0] REQ_ADDR, // Word address
  input  wire logic [`SMB_DATA_W-1:0] REQ_WDATA, // Write data
  input  wire logic [7:0] STROBE_CYCLES,       // Phase length minus one, in cycles
  output logic      BUSY,                      // Access in progress
  output logic      DONE,                      // Access finished, pulse
  output logic [`SMB_DATA_W-1:0] RDATA,        // Read data
  output logic      WAIT_SEEN,                 // Wait level at sample
  smb_bus_if.host   BUS                        // Stacked memory pins
);
  localparam int AW = `SMB_ADDR_W;
  localparam int DW = `SMB_DATA_W;

  smb_pkg::smb_host_state_type st_r, st_nxt;
  smb_pkg::smb_target_type     tgt_r, tgt_nxt;
  logic [7:0]    cnt_r, cnt_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] wd_r, wd_nxt;
  logic          wr_r, wr_nxt, busy_nxt, done_nxt;
  logic [DW-1:0] rd_nxt;
  logic          ws_nxt;
  logic [DW-1:0] dq_s1_r, dq_s2_r;
  logic          w_s1_r, w_s2_r;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      w_s1_r  <= 1'b0;
      w_s2_r  <= 1'b0;
    end else begin
      dq_s1_r <= BUS.dq_dev_oe ? BUS.dq_dev_o : '0;
      dq_s2_r <= dq_s1_r;
      w_s1_r  <= BUS.wait_oe & BUS.wait_o;
      w_s2_r  <= w_s1_r;
    end
  end

  always_comb begin
    st_nxt   = st_r;
    tgt_nxt  = tgt_r;
    cnt_nxt  = cnt_r;
    addr_nxt = addr_r;
    wd_nxt   = wd_r;
    wr_nxt   = wr_r;
    busy_nxt = BUSY;
    done_nxt = 1'b0;
    rd_nxt   = RDATA;
    ws_nxt   = WAIT_SEEN;
    case (st_r)
      smb_pkg::SMB_H_IDLE: begin
        if (REQ) begin
          tgt_nxt  = REQ_TARGET;
          addr_nxt = AW'(REQ_ADDR[`SMB_TOP_LINE_128:0]);
          wd_nxt   = REQ_WDATA;
          wr_nxt   = REQ_WRITE;
          cnt_nxt  = STROBE_CYCLES;
          busy_nxt = 1'b1;
          st_nxt   = REQ_WRITE ? smb_pkg::SMB_H_WRITE : smb_pkg::SMB_H_READ;
        end
      end
      smb_pkg::SMB_H_READ, smb_pkg::SMB_H_WRITE: begin
        if (cnt_r == 8'h00) begin
          st_nxt = smb_pkg::SMB_H_DONE;
          rd_nxt = dq_s2_r;
          ws_nxt = w_s2_r;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      smb_pkg::SMB_H_DONE: begin
        // Address, data held past strobe rise
        done_nxt = 1'b1;
        busy_nxt = 1'b0;
        st_nxt   = smb_pkg::SMB_H_IDLE;
      end
      default: st_nxt = smb_pkg::SMB_H_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r      <= smb_pkg::SMB_H_IDLE;
      tgt_r     <= smb_pkg::SMB_T_FLASH1;
      cnt_r     <= 8'h00;
      addr_r    <= '0;
      wd_r      <= '0;
      wr_r      <= 1'b0;
      BUSY      <= 1'b0;
      DONE      <= 1'b0;
      RDATA     <= '0;
      WAIT_SEEN <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      tgt_r     <= tgt_nxt;
      cnt_r     <= cnt_nxt;
      addr_r    <= addr_nxt;
      wd_r      <= wd_nxt;
      wr_r      <= wr_nxt;
      BUSY      <= busy_nxt;
      DONE      <= done_nxt;
      RDATA     <= rd_nxt;
      WAIT_SEEN <= ws_nxt;
    end
  end

  logic act, rd_ph, wr_ph, is_ram;
  assign rd_ph  = (st_r == smb_pkg::SMB_H_READ);
  assign wr_ph  = (st_r == smb_pkg::SMB_H_WRITE);
  assign act    = rd_ph || wr_ph || (st_r == smb_pkg::SMB_H_DONE);
  assign is_ram = (tgt_r == smb_pkg::SMB_T_SRAM) ||
                  (tgt_r == smb_pkg::SMB_T_PSRAM1) ||
                  (tgt_r == smb_pkg::SMB_T_PSRAM2);

  assign BUS.addr = addr_r;
  assign BUS.flash_sel_n[0] = !(act && tgt_r == smb_pkg::SMB_T_FLASH1);
  assign BUS.flash_sel_n[1] = !(act && tgt_r == smb_pkg::SMB_T_FLASH2);
  assign BUS.flash_sel_n[2] = !(act && tgt_r == smb_pkg::SMB_T_FLASH3);
  assign BUS.sram_select_low_true  = !(act && tgt_r == smb_pkg::SMB_T_SRAM);
  assign BUS.sram_select_high_true = act && tgt_r == smb_pkg::SMB_T_SRAM;
  assign BUS.psram_sel_n[0] = !(act && tgt_r == smb_pkg::SMB_T_PSRAM1);
  assign BUS.psram_sel_n[1] = !(act && tgt_r == smb_pkg::SMB_T_PSRAM2);
  // Enable one for die one only
  assign BUS.flash_oe_n[0] = !(rd_ph && tgt_r == smb_pkg::SMB_T_FLASH1);
  assign BUS.flash_oe_n[1] = !(rd_ph && !is_ram &&
                               tgt_r != smb_pkg::SMB_T_FLASH1);
  assign BUS.ram_oe_n    = !(rd_ph && is_ram);
  // Strobe rises in the done cycle
  assign BUS.flash_we_n  = !(wr_ph && !is_ram);
  assign BUS.ram_we_n    = !(wr_ph && is_ram);
  assign BUS.flash_rst_n = RESET_N;
  assign BUS.dq_host_o  = wd_r;
  assign BUS.dq_host_oe = wr_ph || (st_r == smb_pkg::SMB_H_DONE && wr_r);
endmodule
`default_nettype wire

// >>> bench/smb_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "smb_map.svh"
module smb_chk (
  input wire logic                       CLK_SYS,               // Clock
  input wire logic                       RESET_N,               // Reset
  input wire logic [`SMB_ADDR_W-1:0]     addr,                  // Address
  input wire logic [`SMB_FLASH_DIES-1:0] flash_sel_n,           // Flash sel
  input wire logic                       sram_select_low_true,  // SRAM sel
  input wire logic                       sram_select_high_true, // SRAM sel
  input wire logic [`SMB_PSRAM_DIES-1:0] psram_sel_n,           // PSRAM sel
  input wire logic [1:0]                 flash_oe_n,            // Flash oe
  input wire logic                       ram_oe_n,              // RAM oe
  input wire logic                       flash_we_n,            // Strobe
  input wire logic [`SMB_DATA_W-1:0]     dq_host_o,             // Host data
  input wire logic                       dq_host_oe,            // Host oe
  input wire logic                       dq_dev_oe,             // Dev oe
  input wire logic                       wait_oe                // Wait oe
);
  logic [5:0] en_vec;
  logic       fl_on;
  logic       ram_any;
  assign en_vec[0] = ~flash_sel_n[0] & ~flash_oe_n[0];
  assign en_vec[1] = ~flash_sel_n[1] & ~flash_oe_n[1];
  assign en_vec[2] = ~flash_sel_n[2] & ~flash_oe_n[1];
  assign en_vec[3] = ~ram_oe_n & ~sram_select_low_true
                     & sram_select_high_true;
  assign en_vec[4] = ~ram_oe_n & ~psram_sel_n[0];
  assign en_vec[5] = ~ram_oe_n & ~psram_sel_n[1];
  assign fl_on = ~&flash_sel_n;
  assign ram_any = ~sram_select_low_true | sram_select_high_true
                   | ~&psram_sel_n;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);
  sequence all_idle_s;
    (!fl_on && !ram_any)[*5];
  endsequence
  sequence oe_off_s;
    (&flash_oe_n && ram_oe_n)[*5];
  endsequence
  sequence fl_idle_s;
    (!fl_on)[*5];
  endsequence
  sequence fl_noe_s;
    (fl_on && &flash_oe_n)[*5];
  endsequence
  sequence fl_rd_s;
    (|en_vec[2:0])[*5];
  endsequence
  sequence ram_rd_s;
    (|en_vec[5:3])[*5];
  endsequence
  idle_release_a: assert property (all_idle_s |-> !dq_dev_oe)
    else $error("data driven while deselected");
  oe_release_a: assert property (oe_off_s |-> !dq_dev_oe)
    else $error("data driven while outputs off");
  wait_float_a: assert property (fl_idle_s |-> !wait_oe)
    else $error("wait driven while flash deselected");
  wait_ungated_a: assert property (fl_noe_s |-> wait_oe)
    else $error("wait gated by output enable");
  flash_drive_a: assert property (fl_rd_s |-> dq_dev_oe)
    else $error("flash read not driven");
  ram_drive_a: assert property (ram_rd_s |-> dq_dev_oe)
    else $error("ram read not driven");
  one_die_a: assert property ($countones(en_vec) <= 1)
    else $error("two dies enabled");
  addr_top_a: assert property (
    addr[`SMB_ADDR_W-1:`SMB_TOP_LINE_128+1] == '0)
    else $error("address driven above top line");
  strobe_hold_a: assert property ($rose(flash_we_n) |->
    $past(dq_host_oe) && $stable(addr) && $stable(dq_host_o) && fl_on)
    else $error("write strobe rise without held bus");
  strobe_die_a: assert property (!flash_we_n |->
    $onehot(~flash_sel_n) && dq_host_oe)
    else $error("write strobe without one die and data");
endmodule
`default_nettype wire

// >>> bench/stacked_memory_bus_select_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "smb_map.svh"
module stacked_memory_bus_select_tb;
  logic                       clk_sys;
  logic                       reset_n;
  logic                       req;
  logic                       req_write;
  smb_pkg::smb_target_type    req_target;
  logic [`SMB_ADDR_W-1:0]     req_addr;
  logic [`SMB_DATA_W-1:0]     req_wdata;
  logic [7:0]                 strobe_cycles;
  logic                       busy;
  logic                       done;
  logic [`SMB_DATA_W-1:0]     rdata;
  logic                       wait_seen;
  logic [`SMB_FLASH_DIES-1:0] act_flash;
  logic                       act_sram;
  logic [`SMB_PSRAM_DIES-1:0] act_psram;
  logic                       wait_pol;
  integer                     error_cnt;
  integer                     comparisons;
  integer                     seed;
  logic [5:0]                 act_all;
  integer                     mem [0:5][0:15];
  integer                     pol [0:2];
  integer                     syn [0:2];
  integer                     pend [0:2];
  smb_bus_if bus ();
  smb_host smb_host_i (.CLK_SYS(clk_sys), .RESET_N(reset_n), .REQ(req),
    .REQ_WRITE(req_write), .REQ_TARGET(req_target), .REQ_ADDR(req_addr),
    .REQ_WDATA(req_wdata), .STROBE_CYCLES(strobe_cycles), .BUSY(busy),
    .DONE(done), .RDATA(rdata), .WAIT_SEEN(wait_seen), .BUS(bus));
  smb_device smb_device_i (.CLK_SYS(clk_sys), .RESET_N(reset_n), .BUS(bus),
    .ACTIVE_FLASH(act_flash), .ACTIVE_SRAM(act_sram),
    .ACTIVE_PSRAM(act_psram), .WAIT_POL(wait_pol));
  smb_chk smb_chk_i (.CLK_SYS(clk_sys), .RESET_N(reset_n), .addr(bus.addr),
    .flash_sel_n(bus.flash_sel_n), .psram_sel_n(bus.psram_sel_n),
    .sram_select_low_true(bus.sram_select_low_true),
    .sram_select_high_true(bus.sram_select_high_true),
    .flash_oe_n(bus.flash_oe_n), .ram_oe_n(bus.ram_oe_n),
    .flash_we_n(bus.flash_we_n), .dq_host_o(bus.dq_host_o),
    .dq_host_oe(bus.dq_host_oe), .dq_dev_oe(bus.dq_dev_oe),
    .wait_oe(bus.wait_oe));

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  assign act_all = {act_psram, act_sram, act_flash};

  task automatic idle_check;
    repeat (8) @(posedge clk_sys);
    #1;
    check("idle active", 16'(act_all), 16'h0000);
  endtask

  task automatic access(input logic wr, input int t,
                        input logic [25:0] a, input logic [15:0] d);
    int n;
    int w;
    @(posedge clk_sys);
    #1;
    req = 1'b1;
    req_write = wr;
    req_target = smb_pkg::smb_target_type'(t);
    req_addr = a;
    req_wdata = d;
    @(posedge clk_sys);
    #1;
    req = 1'b0;
    check("busy", 16'(busy), 16'h0001);
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      #1;
      n = n + 1;
    end
    check("done delay", 16'(n), 16'(strobe_cycles + 2));
    check("busy end", 16'(busy), 16'h0000);
    check("active", 16'(act_all), 16'(1 << t));
    w = 0;
    if (t < 3) begin
      w = (syn[t] != 0) ? !pol[t] : pol[t];
    end
    check("wait seen", 16'(wait_seen), 16'(w));
    if (!wr) begin
      check("read data", rdata, 16'(mem[t][a[3:0]]));
    end else if (t > 2) begin
      mem[t][a[3:0]] = d;
    end else if (pend[t] != 0) begin
      pend[t] = 0;
      syn[t] = (d == 16'h0003);
      if (d == 16'h0003) begin
        pol[t] = a[10];
      end
    end else if (d == 16'h0060) begin
      pend[t] = 1;
      syn[t] = 0;
    end else begin
      syn[t] = 0;
      mem[t][a[3:0]] = d;
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    give_verdict();
  end

  initial begin
    logic [25:0] a;
    logic [15:0] d;
    int          t;
    error_cnt = 0;
    comparisons = 0;
    seed = 52;
    for (t = 0; t < 3; t++) begin
      pol[t] = 1;
      syn[t] = 0;
      pend[t] = 0;
    end
    reset_n = 1'b0;
    req = 1'b0;
    req_write = 1'b0;
    req_target = smb_pkg::SMB_T_FLASH1;
    req_addr = 26'h0000000;
    req_wdata = 16'h0000;
    strobe_cycles = 8'h05;
    repeat (20) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    check("wait pol reset", 16'(wait_pol), 16'h0001);
    check("reset active", 16'(act_all), 16'h0000);
    for (t = 0; t < 6; t++) begin
      a = 26'($random(seed));
      a[3:0] = {2'(t + 1), 2'($random(seed))};
      d = 16'h8000 | 16'($random(seed));
      access(1'b1, t, a, d);
      idle_check();
      access(1'b0, t, a ^ 26'h3000000, 16'h0000);
      idle_check();
    end
    for (t = 0; t < 3; t++) begin
      access(1'b1, 0, 26'h0000000, 16'h0060);
      d = (t == 2) ? 16'h00FF : 16'h0003;
      access(1'b1, 0, 26'(t << 10), d);
      repeat (4) @(posedge clk_sys);
      #1;
      check("wait pol", 16'(wait_pol), 16'(pol[0]));
    end
    repeat (20) begin
      t = {$random(seed)} % 3;
      strobe_cycles = 8'(5 + {$random(seed)} % 8);
      a = 26'($random(seed));
      a[3:0] = {2'(t + 1), 2'($random(seed))};
      d = 16'h8000 | 16'($random(seed));
      access(1'b1, t, a, d);
      access(1'b0, t, a ^ 26'h1000000, 16'h0000);
    end
    idle_check();
    give_verdict();
  end
endmodule
`default_nettype wire
